// File: shared/tcc_pkg.sv
// Notes on behaviour
// - counter reset write clears count and captures, then stops counting
// - writing one to the run bit restarts a stopped counter
// - config two reads index level bit 6, line a bit 5, line b bit 4
// - terminal count sets its flag; only writing zero clears it
// - compare match sets its flag; only writing zero clears it
// - encoder index or terminal event captures the count when enabled
// - clear-after-capture zeroes the count on capture, else no effect
// - enabled rising edges of the capture input are capture events
// - enabled falling edges of the capture input are capture events
// - soft rise strobe copies the count to rise capture and self-clears
// - soft fall strobe copies the count to fall capture and self-clears
// - all capture sources may act together, none excludes another
// - period is written high then low; low write applies both bytes
// - reading the period pair returns the live count
// - compare is written high then low; low write applies both bytes
// - rise capture pair is read only and resets to zero
package tcc_pkg;

   localparam int unsigned TCC_AW = 16;
   localparam int unsigned TCC_DW = 8;
   localparam int unsigned TCC_CW = 16;

   // register addresses
   localparam logic [15:0] TCC_RUN_CTRL = 16'ha058;
   localparam logic [15:0] TCC_CONFIG_TWO = 16'ha051;
   localparam logic [15:0] TCC_CONFIG_THREE = 16'ha052;
   localparam logic [15:0] TCC_PERIOD_LOW = 16'ha054;
   localparam logic [15:0] TCC_PERIOD_HIGH = 16'ha055;
   localparam logic [15:0] TCC_COMPARE_LOW = 16'ha056;
   localparam logic [15:0] TCC_COMPARE_HIGH = 16'ha057;
   localparam logic [15:0] TCC_RISE_CAP_LOW = 16'ha060;
   localparam logic [15:0] TCC_RISE_CAP_HIGH = 16'ha061;
   localparam logic [15:0] TCC_FALL_CAP_LOW = 16'ha062;
   localparam logic [15:0] TCC_FALL_CAP_HIGH = 16'ha063;

   // config two fields
   localparam int unsigned CFG2_RESET_BIT = 7;
   localparam int unsigned CFG2_INDEX_BIT = 6;
   localparam int unsigned CFG2_LINE_A_BIT = 5;
   localparam int unsigned CFG2_LINE_B_BIT = 4;
   localparam int unsigned CFG2_TPOL_BIT = 3;
   localparam int unsigned CFG2_CPOL_BIT = 2;
   localparam int unsigned CFG2_TFLAG_BIT = 1;
   localparam int unsigned CFG2_CFLAG_BIT = 0;

   // run control field
   localparam int unsigned RUN_BIT = 0;

   // reset values
   localparam logic [7:0] TCC_BYTE_RST = 8'h00;
   localparam logic [15:0] TCC_WORD_RST = 16'h0000;

   typedef struct packed {
      logic terminal_irq_enable;
      logic compare_irq_enable;
      logic encoder_capture_enable;
      logic clear_after_capture;
      logic rising_capture_enable;
      logic falling_capture_enable;
      logic soft_rise_capture;
      logic soft_fall_capture;
   } tcc_cfg3_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } tcc_bus_req_s;

   typedef struct packed {
      logic index_level;
      logic line_a_level;
      logic line_b_level;
      logic index_event;
      logic terminal_event;
   } tcc_encoder_s;

endpackage

// File: verilog/tcc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_timer
   import tcc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // register port
   input wire tcc_bus_req_s bus_req,
   output logic [TCC_DW-1:0] bus_rdata,
   // capture pin and encoder
   input wire logic capture_in,
   input wire tcc_encoder_s encoder,
   // outputs
   output logic terminal_output,
   output logic compare_output,
   output logic irq
);

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [TCC_CW-1:0] timer_count_reg;
   logic [TCC_CW-1:0] timer_count_next;
   logic [TCC_CW-1:0] period_value_reg;
   logic [TCC_CW-1:0] compare_value_reg;
   logic [TCC_DW-1:0] period_high_buf_reg;
   logic [TCC_DW-1:0] compare_high_buf_reg;
   logic [TCC_CW-1:0] rise_capture_value_reg;
   logic [TCC_CW-1:0] fall_capture_value_reg;
   logic running_reg;
   logic terminal_output_polarity_reg;
   logic compare_output_polarity_reg;
   logic terminal_count_flag_reg;
   logic compare_match_flag_reg;
   tcc_cfg3_s cfg3_reg;
   logic capture_in_prev_reg;
   logic terminal_pulse_reg;
   logic compare_level_reg;
   logic [TCC_DW-1:0] rdata_reg;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   logic wr_run;
   logic wr_cfg2;
   logic wr_cfg3;
   logic wr_prd_lo;
   logic wr_prd_hi;
   logic wr_cmp_lo;
   logic wr_cmp_hi;
   logic counter_reset;
   logic [TCC_DW-1:0] wd;

   assign wd = bus_req.wdata;
   assign wr_run = bus_req.wr && (bus_req.addr == TCC_RUN_CTRL);
   assign wr_cfg2 = bus_req.wr && (bus_req.addr == TCC_CONFIG_TWO);
   assign wr_cfg3 = bus_req.wr && (bus_req.addr == TCC_CONFIG_THREE);
   assign wr_prd_lo = bus_req.wr && (bus_req.addr == TCC_PERIOD_LOW);
   assign wr_prd_hi = bus_req.wr && (bus_req.addr == TCC_PERIOD_HIGH);
   assign wr_cmp_lo = bus_req.wr && (bus_req.addr == TCC_COMPARE_LOW);
   assign wr_cmp_hi = bus_req.wr && (bus_req.addr == TCC_COMPARE_HIGH);
   assign counter_reset = wr_cfg2 && wd[CFG2_RESET_BIT];

   // ------------------------------------------------------------
   // capture events
   // ------------------------------------------------------------
   logic edge_rise;
   logic edge_fall;
   logic encoder_event;
   logic rise_event;
   logic fall_event;
   logic any_capture;
   logic terminal_hit;
   logic compare_hit;

   // capture_in is taken as already synchronous to core_clk
   assign edge_rise = capture_in && !capture_in_prev_reg;
   assign edge_fall = !capture_in && capture_in_prev_reg;
   assign encoder_event = cfg3_reg.encoder_capture_enable &&
      (encoder.index_event || encoder.terminal_event);
   // sources are or-ed, so several may fire in one cycle
   assign rise_event = (cfg3_reg.rising_capture_enable && edge_rise) ||
      cfg3_reg.soft_rise_capture || encoder_event;
   assign fall_event = (cfg3_reg.falling_capture_enable && edge_fall) ||
      cfg3_reg.soft_fall_capture;
   assign any_capture = rise_event || fall_event;
   assign terminal_hit = running_reg &&
      (timer_count_reg == period_value_reg);
   assign compare_hit = running_reg &&
      (timer_count_reg == compare_value_reg);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         capture_in_prev_reg <= 1'b0;
      end else begin
         capture_in_prev_reg <= capture_in;
      end
   end

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   always_comb begin
      timer_count_next = timer_count_reg;
      if (counter_reset) begin
         timer_count_next = TCC_WORD_RST;
      end else if (any_capture && cfg3_reg.clear_after_capture) begin
         timer_count_next = TCC_WORD_RST;
      end else if (terminal_hit) begin
         timer_count_next = TCC_WORD_RST;
      end else if (running_reg) begin
         timer_count_next = timer_count_reg + 16'h0001;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         timer_count_reg <= TCC_WORD_RST;
      end else begin
         timer_count_reg <= timer_count_next;
      end
   end

   // reset strobe wins over a run write in the same cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         running_reg <= 1'b0;
      end else if (counter_reset) begin
         running_reg <= 1'b0;
      end else if (wr_run && wd[RUN_BIT]) begin
         running_reg <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // period and compare, high byte buffered
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         period_high_buf_reg <= TCC_BYTE_RST;
         period_value_reg <= TCC_WORD_RST;
      end else begin
         if (wr_prd_hi) begin
            period_high_buf_reg <= wd;
         end
         if (wr_prd_lo) begin
            period_value_reg <= {period_high_buf_reg, wd};
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         compare_high_buf_reg <= TCC_BYTE_RST;
         compare_value_reg <= TCC_WORD_RST;
      end else begin
         if (wr_cmp_hi) begin
            compare_high_buf_reg <= wd;
         end
         if (wr_cmp_lo) begin
            compare_value_reg <= {compare_high_buf_reg, wd};
         end
      end
   end

   // ------------------------------------------------------------
   // capture registers
   // ------------------------------------------------------------
   // only the counter reset write reaches these, so they stay read only
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rise_capture_value_reg <= TCC_WORD_RST;
      end else if (counter_reset) begin
         rise_capture_value_reg <= TCC_WORD_RST;
      end else if (rise_event) begin
         rise_capture_value_reg <= timer_count_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fall_capture_value_reg <= TCC_WORD_RST;
      end else if (counter_reset) begin
         fall_capture_value_reg <= TCC_WORD_RST;
      end else if (fall_event) begin
         fall_capture_value_reg <= timer_count_reg;
      end
   end

   // ------------------------------------------------------------
   // configuration
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         terminal_output_polarity_reg <= 1'b0;
         compare_output_polarity_reg <= 1'b0;
      end else if (wr_cfg2) begin
         terminal_output_polarity_reg <= wd[CFG2_TPOL_BIT];
         compare_output_polarity_reg <= wd[CFG2_CPOL_BIT];
      end
   end

   // soft strobes live one cycle, then clear themselves
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cfg3_reg <= tcc_cfg3_s'(TCC_BYTE_RST);
      end else begin
         if (wr_cfg3) begin
            cfg3_reg <= tcc_cfg3_s'(wd);
         end else begin
            cfg3_reg.soft_rise_capture <= 1'b0;
            cfg3_reg.soft_fall_capture <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // flags and interrupt
   // ------------------------------------------------------------
   // a set in the same cycle as a clearing write wins
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         terminal_count_flag_reg <= 1'b0;
      end else if (terminal_hit) begin
         terminal_count_flag_reg <= 1'b1;
      end else if (wr_cfg2 && !wd[CFG2_TFLAG_BIT]) begin
         terminal_count_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         compare_match_flag_reg <= 1'b0;
      end else if (compare_hit) begin
         compare_match_flag_reg <= 1'b1;
      end else if (wr_cfg2 && !wd[CFG2_CFLAG_BIT]) begin
         compare_match_flag_reg <= 1'b0;
      end
   end

   assign irq =
      (terminal_count_flag_reg && cfg3_reg.terminal_irq_enable) ||
      (compare_match_flag_reg && cfg3_reg.compare_irq_enable);

   // ------------------------------------------------------------
   // pin outputs
   // ------------------------------------------------------------
   // outputs are registered so the pins never glitch on a compare
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         terminal_pulse_reg <= 1'b0;
         compare_level_reg <= 1'b0;
      end else begin
         terminal_pulse_reg <= terminal_hit;
         compare_level_reg <= running_reg &&
            (timer_count_reg >= compare_value_reg);
      end
   end

   assign terminal_output =
      terminal_pulse_reg ^ terminal_output_polarity_reg;
   assign compare_output =
      compare_level_reg ^ compare_output_polarity_reg;

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   logic [TCC_DW-1:0] rd_mux;
   logic [TCC_DW-1:0] cfg2_view;

   always_comb begin
      cfg2_view = TCC_BYTE_RST;
      cfg2_view[CFG2_INDEX_BIT] = encoder.index_level;
      cfg2_view[CFG2_LINE_A_BIT] = encoder.line_a_level;
      cfg2_view[CFG2_LINE_B_BIT] = encoder.line_b_level;
      cfg2_view[CFG2_TPOL_BIT] = terminal_output_polarity_reg;
      cfg2_view[CFG2_CPOL_BIT] = compare_output_polarity_reg;
      cfg2_view[CFG2_TFLAG_BIT] = terminal_count_flag_reg;
      cfg2_view[CFG2_CFLAG_BIT] = compare_match_flag_reg;
   end

   always_comb begin
      rd_mux = TCC_BYTE_RST;
      unique case (bus_req.addr)
         TCC_RUN_CTRL: begin
            rd_mux[RUN_BIT] = running_reg;
         end
         TCC_CONFIG_TWO: begin
            rd_mux = cfg2_view;
         end
         TCC_CONFIG_THREE: begin
            // strobe bits read as zero
            rd_mux = {cfg3_reg[7:2], 2'h0};
         end
         TCC_PERIOD_LOW: begin
            rd_mux = timer_count_reg[7:0];
         end
         TCC_PERIOD_HIGH: begin
            rd_mux = timer_count_reg[15:8];
         end
         TCC_COMPARE_LOW: begin
            rd_mux = compare_value_reg[7:0];
         end
         TCC_COMPARE_HIGH: begin
            rd_mux = compare_value_reg[15:8];
         end
         TCC_RISE_CAP_LOW: begin
            rd_mux = rise_capture_value_reg[7:0];
         end
         TCC_RISE_CAP_HIGH: begin
            rd_mux = rise_capture_value_reg[15:8];
         end
         TCC_FALL_CAP_LOW: begin
            rd_mux = fall_capture_value_reg[7:0];
         end
         TCC_FALL_CAP_HIGH: begin
            rd_mux = fall_capture_value_reg[15:8];
         end
         default: begin
            rd_mux = TCC_BYTE_RST;
         end
      endcase
   end

   // data valid only in the cycle after the read strobe
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= TCC_BYTE_RST;
      end else if (bus_req.rd) begin
         rdata_reg <= rd_mux;
      end else begin
         rdata_reg <= TCC_BYTE_RST;
      end
   end

   assign bus_rdata = rdata_reg;

endmodule
`default_nettype wire

// File: verification/tcc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_partner
   import tcc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // scenario commands
   input wire logic pin_cmd,
   input wire logic index_cmd,
   input wire logic term_cmd,
   input wire logic [2:0] level_cmd,
   // far-side lines
   output logic capture_in,
   output tcc_encoder_s encoder
);
   // -----------------------------------------
   // pin and decoder lines
   // -----------------------------------------
   // one register stage, so every line moves just after an edge
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         capture_in <= 1'b0;
         encoder <= '0;
      end else begin
         capture_in <= pin_cmd;
         encoder <= {level_cmd, index_cmd, term_cmd};
      end
   end
endmodule
`default_nettype wire

// File: verification/tcc_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_checker
   import tcc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // watched ports
   input wire tcc_bus_req_s bus_req,
   input wire logic [TCC_DW-1:0] bus_rdata,
   input wire logic capture_in,
   input wire tcc_encoder_s encoder,
   input wire logic terminal_output,
   input wire logic compare_output,
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire rd_c2 = bus_req.rd && bus_req.addr == TCC_CONFIG_TWO;
   wire wr_c2 = bus_req.wr && bus_req.addr == TCC_CONFIG_TWO;
   wire rd_c3 = bus_req.rd && bus_req.addr == TCC_CONFIG_THREE;
   wire wr_c3 = bus_req.wr && bus_req.addr == TCC_CONFIG_THREE;
   // -----------------------------------------
   // assertions and covers
   // -----------------------------------------
   a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   a_rdata_unmapped: assert property (bus_req.rd &&
      bus_req.addr[15:8] != 8'ha0 |=> bus_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_live_levels: assert property (rd_c2 |=> bus_rdata[7:4] == {1'b0,
      $past({encoder.index_level, encoder.line_a_level,
      encoder.line_b_level})})
      else $error("level bits wrong");
   a_strobe_clear: assert property (rd_c3 |=>
      bus_rdata[1:0] == 2'b00)
      else $error("soft strobe bits not clear");
   a_stop_outputs: assert property (wr_c2 && bus_req.wdata[7] ##1
      !bus_req.wr [*2] |-> {terminal_output, compare_output} ==
      $past(bus_req.wdata[3:2], 2))
      else $error("stopped outputs not at polarity");
   a_irq_masked: assert property (wr_c3 &&
      bus_req.wdata[7:6] == 2'b00 |=> !irq)
      else $error("irq high with both enables off");
   a_pol_readback: assert property (wr_c2 ##1 rd_c2 |=>
      bus_rdata[3:2] == $past(bus_req.wdata[3:2], 2))
      else $error("polarity readback wrong");
   a_cfg3_readback: assert property (wr_c3 ##1 rd_c3 |=>
      bus_rdata[7:2] == $past(bus_req.wdata[7:2], 2))
      else $error("config three readback wrong");
   a_compare_pair: assert property (bus_req.wr &&
      bus_req.addr == TCC_COMPARE_HIGH ##1 bus_req.wr &&
      bus_req.addr == TCC_COMPARE_LOW ##1 bus_req.rd &&
      bus_req.addr == TCC_COMPARE_HIGH |=>
      bus_rdata == $past(bus_req.wdata, 3))
      else $error("compare high not applied");
   c_cap_read: cover property (bus_req.rd &&
      bus_req.addr == TCC_RISE_CAP_LOW);
   c_irq: cover property ($rose(irq));
   c_pin: cover property ($rose(capture_in));
endmodule
`default_nettype wire

// File: verification/tcc_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_tb
   import tcc_pkg::*;
;
   logic core_clk, rstn, capture_in, terminal_output, compare_output, irq;
   logic pin_cmd, index_cmd, term_cmd, rd_seen;
   logic [2:0] level_cmd, lv;
   logic [7:0] bus_rdata, ex;
   logic [15:0] note;
   logic [15:0] notes[$];
   tcc_bus_req_s bus_req;
   tcc_encoder_s encoder;
   int errors, checks, seed, i;

   tcc_timer i_dut (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .capture_in(capture_in), .encoder(encoder),
      .terminal_output(terminal_output), .compare_output(compare_output),
      .irq(irq));
   tcc_partner i_far (.core_clk(core_clk), .rstn(rstn), .pin_cmd(pin_cmd),
      .index_cmd(index_cmd), .term_cmd(term_cmd), .level_cmd(level_cmd),
      .capture_in(capture_in), .encoder(encoder));

   // -----------------------------------------
   // tasks
   // -----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t ns: got %h expected %h", $time,
            got, exp);
      end
   endtask
   task automatic put(input logic rd, input logic [15:0] a,
      input logic [7:0] d);
      @(posedge core_clk);
      bus_req <= '{rd: rd, wr: !rd, addr: a, wdata: d};
   endtask
   // read data are compared later by the monitor, masked bits only
   task automatic get(input logic [15:0] a, input logic [7:0] e,
      input logic [7:0] m);
      notes.push_back({m, e & m});
      put(1'b1, a, 8'h00);
   endtask
   task automatic idle(input int n);
      @(posedge core_clk);
      bus_req <= '0;
      repeat (n) @(posedge core_clk);
   endtask
   task automatic give_verdict;
      if (errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // -----------------------------------------
   // clock, monitor, watchdog
   // -----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) rd_seen <= bus_req.rd;
   always @(negedge core_clk) begin
      if (rd_seen === 1'b1) begin
         if (notes.size() == 0) errors++;
         else begin
            note = notes.pop_front();
            chk(bus_rdata & note[15:8], note[7:0]);
         end
      end
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      errors++;
      give_verdict();
   end

   // -----------------------------------------
   // main sequence
   // -----------------------------------------
   initial begin
      seed = 95337;
      errors = 0;
      checks = 0;
      bus_req = '0;
      {pin_cmd, index_cmd, term_cmd, level_cmd} = '0;
      rstn = 1'b0;
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      put(1'b0, TCC_PERIOD_HIGH, 8'h00);
      put(1'b0, TCC_PERIOD_LOW, 8'h03);
      put(1'b0, TCC_COMPARE_HIGH, 8'h00);
      put(1'b0, TCC_COMPARE_LOW, 8'h02);
      get(TCC_COMPARE_HIGH, 8'h00, 8'hff);
      get(TCC_COMPARE_LOW, 8'h02, 8'hff);
      put(1'b0, TCC_CONFIG_TWO, 8'h83);
      put(1'b0, TCC_RUN_CTRL, 8'h01);
      // count wraps after three; pins looked at mid-cycle, once settled
      for (i = 0; i < 9; i++) begin
         get(TCC_PERIOD_LOW, 8'(i % 4), 8'hff);
         @(negedge core_clk);
         ex = (i > 0 && i % 4 == 0) ? 8'h03 : (i % 4 == 3) ? 8'h01 : 8'h00;
         chk({6'h00, terminal_output, compare_output}, ex);
      end
      get(TCC_PERIOD_HIGH, 8'h00, 8'hff);
      put(1'b0, TCC_CONFIG_THREE, 8'hc0);
      get(TCC_CONFIG_THREE, 8'hc0, 8'hff);
      put(1'b0, TCC_CONFIG_TWO, 8'h8f);
      get(TCC_CONFIG_TWO, 8'h0f, 8'h8f);
      get(TCC_PERIOD_LOW, 8'h00, 8'hff);
      get(TCC_PERIOD_LOW, 8'h00, 8'hff);
      @(negedge core_clk);
      chk({5'h00, terminal_output, compare_output, irq}, 8'h07);
      put(1'b0, TCC_CONFIG_TWO, 8'h02);
      get(TCC_CONFIG_TWO, 8'h02, 8'h03);
      idle(1);
      @(negedge core_clk);
      chk({5'h00, terminal_output, compare_output, irq}, 8'h01);
      put(1'b0, TCC_CONFIG_THREE, 8'h40);
      idle(1);
      @(negedge core_clk);
      chk({7'h00, irq}, 8'h00);
      put(1'b0, TCC_CONFIG_TWO, 8'h00);
      get(TCC_CONFIG_TWO, 8'h00, 8'h03);
      // random levels of the decoder lines
      for (i = 0; i < 4; i++) begin
         lv = 3'($random(seed));
         level_cmd <= lv;
         idle(2);
         get(TCC_CONFIG_TWO, {1'b0, lv, 4'h0}, 8'hf0);
      end
      put(1'b0, TCC_PERIOD_HIGH, 8'hff);
      put(1'b0, TCC_PERIOD_LOW, 8'hff);
      put(1'b0, TCC_CONFIG_TWO, 8'h80);
      put(1'b0, TCC_RUN_CTRL, 8'h01);
      put(1'b0, TCC_CONFIG_THREE, 8'h02);
      put(1'b0, TCC_CONFIG_THREE, 8'h01);
      get(TCC_RISE_CAP_LOW, 8'h01, 8'hff);
      put(1'b0, TCC_RISE_CAP_LOW, 8'h5a);
      get(TCC_RISE_CAP_HIGH, 8'h00, 8'hff);
      get(TCC_RISE_CAP_LOW, 8'h01, 8'hff);
      get(TCC_FALL_CAP_LOW, 8'h02, 8'hff);
      get(TCC_CONFIG_THREE, 8'h00, 8'h03);
      // captures hold non-zero values here, so the reset is visible
      put(1'b0, TCC_CONFIG_TWO, 8'h80);
      get(TCC_RISE_CAP_LOW, 8'h00, 8'hff);
      get(TCC_FALL_CAP_LOW, 8'h00, 8'hff);
      put(1'b0, TCC_RUN_CTRL, 8'h01);
      // pin rise clears, decoder event mid-way, pin fall last
      put(1'b0, TCC_CONFIG_THREE, 8'h3c);
      for (i = 0; i < 2; i++) begin
         idle(0);
         pin_cmd <= 1'b1;
         repeat (3) @(posedge core_clk);
         if (i == 0) index_cmd <= 1'b1;
         else term_cmd <= 1'b1;
         @(posedge core_clk);
         index_cmd <= 1'b0;
         term_cmd <= 1'b0;
         repeat (3) @(posedge core_clk);
         pin_cmd <= 1'b0;
         idle(3);
         get(TCC_RISE_CAP_LOW, 8'h02, 8'hff);
         get(TCC_FALL_CAP_LOW, 8'h03, 8'hff);
         @(negedge core_clk);
         chk({6'h00, terminal_output, compare_output}, 8'h01);
      end
      get(16'hb000, 8'h00, 8'hff);
      idle(3);
      if (notes.size() != 0) errors++;
      give_verdict();
   end
endmodule

bind tcc_timer tcc_timer_checker i_chk (.core_clk(core_clk), .rstn(rstn),
   .bus_req(bus_req), .bus_rdata(bus_rdata), .capture_in(capture_in),
   .encoder(encoder), .terminal_output(terminal_output),
   .compare_output(compare_output), .irq(irq));
`default_nettype wire
